/* core/nva_pkg.sv */
/*
 * Constants, field layouts and types shared by the data EEPROM access
 * controller, the firmware master model and the testbench.
 * Assumes a 40 MHz core clock and a byte-addressed Avalon-MM slave port.
 */
package nva_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int POWERUP_DELAY_MS = 72;
	localparam int POWERUP_DELAY_CYCLES = POWERUP_DELAY_MS * (CLK_HZ / 1000);
	localparam int STORE_CYCLES = 400;
	localparam int KEY_GAP_CYCLES = 2;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CONTROL = 8'h9c;
	localparam logic [7:0] OFF_KEY = 8'ha0;
	localparam logic [7:0] OFF_BYTE = 8'ha4;
	localparam logic [7:0] OFF_INDEX = 8'ha8;
	localparam logic [7:0] OFF_FLAG = 8'hac;

	// ------------------------------------------------------------
	// Field positions, key values and reset values
	// ------------------------------------------------------------
	localparam int FETCH_BIT = 0;
	localparam int STORE_BIT = 1;
	localparam int PERMIT_BIT = 2;
	localparam int ABORT_BIT = 3;
	localparam int DONE_BIT = 7;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [3:0] CONTROL_RST = 4'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] INDEX_RST = 8'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic abort;
		logic permit;
		logic store;
		logic fetch;
	} nva_ctrl_t;

	typedef enum logic [2:0] {
		KEY_IDLE = 3'b001,
		KEY_HALF = 3'b010,
		KEY_FULL = 3'b100
	} nva_key_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} nva_store_t;

endpackage : nva_pkg

/* core/nva_mem.sv */
/*
 * Byte array of the data EEPROM with a registered read port.
 * Assumes the controller drives at most one write per cycle.
 */
module nva_mem #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [ADDR_W-1:0] waddr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [ADDR_W-1:0] raddr,
	output logic [DATA_W-1:0] rdata
);

	logic [DATA_W-1:0] cells [2**ADDR_W];

	// A write replaces the whole byte, so no separate erase is needed.
	always_ff @(posedge clk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= cells[raddr];
		end
	end

endmodule : nva_mem

/* core/nva_ctrl.sv */
/*
 * Data EEPROM access controller: control, key, byte, index and flag
 * registers on an Avalon-MM slave, the unlock sequence checker, the
 * store timer and the power-up write lockout.
 * Assumes synchronous reset-request pulses and a firmware master.
 */

// How it works
// - control register upper four bits read zero.
// - triggers set by software, cleared by hardware.
// - store permit enables writes, cleared at power-up.
// - abort flag set when reset kills store.
// - byte and index registers survive aborting resets.
// - completion clears trigger, sets sticky done flag.
// - key port stores nothing, reads zero.
// - fetch loads byte next cycle, then clears.
// - byte register holds until fetch or write.
// - key 55h then AAh then store trigger.
// - wrong cycle spacing in sequence discards write.
// - store trigger blocked while permit is clear.
// - clearing permit never disturbs running store.
// - hardware never clears store permit itself.
// - power-up delay blocks writes for its duration.
// - byte store replaces cell, timed on chip.
// - array holds 128 or 256 bytes.
module nva_ctrl #(
	parameter int ADDR_W = 7,
	parameter int POWERUP_DELAY_CYCLES = nva_pkg::POWERUP_DELAY_CYCLES,
	parameter int STORE_CYCLES = nva_pkg::STORE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic external_reset_pin,
	input wire logic watchdog_timeout,
	input wire logic brownout_reset,
	input wire logic powerup_timer_en,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	localparam int CW = $clog2(STORE_CYCLES);
	localparam int PW = $clog2(POWERUP_DELAY_CYCLES + 1);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		return a == off;
	endfunction : hit

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic wait_reg;
	logic [31:0] rdata_reg;
	nva_pkg::nva_ctrl_t ctrl_reg;
	nva_pkg::nva_key_t key_reg;
	nva_pkg::nva_store_t st_reg;
	logic [3:0] gap_reg;
	logic [CW-1:0] st_cnt_reg;
	logic [7:0] byte_reg;
	logic [7:0] index_reg;
	logic [7:0] st_data_reg;
	logic [ADDR_W-1:0] st_addr_reg;
	logic done_reg;
	logic started_reg;
	logic powerup_on_reg;
	logic [PW-1:0] powerup_cnt_reg;
	logic [7:0] mem_rdata;

	logic acc_rd;
	logic acc_wr;
	logic lane0;
	logic [7:0] wbyte;
	logic sys_abort;
	logic ctl_wr;
	logic key_wr;
	logic gap_ok;
	logic powerup_block;
	logic busy;
	logic st_last;
	logic store_start;
	logic store_done;
	logic store_kill;
	logic [7:0] rd_mux;

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	// An access is taken at the edge where waitrequest is seen low.
	assign acc_rd = avs_read & ~wait_reg;
	assign acc_wr = avs_write & ~wait_reg;
	assign lane0 = avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];
	assign ctl_wr = acc_wr & lane0 & hit(avs_address, nva_pkg::OFF_CONTROL);
	assign key_wr = acc_wr & lane0 & hit(avs_address, nva_pkg::OFF_KEY);
	assign sys_abort = external_reset_pin | watchdog_timeout |
		brownout_reset;

	// Waitrequest idles high and drops for exactly one cycle per access.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 1'b1;
		end else if (!wait_reg) begin
			wait_reg <= 1'b1;
		end else if (avs_read | avs_write) begin
			wait_reg <= 1'b0;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		if (hit(avs_address, nva_pkg::OFF_CONTROL)) begin
			rd_mux = {4'h0, ctrl_reg};
		end else if (hit(avs_address, nva_pkg::OFF_BYTE)) begin
			rd_mux = byte_reg;
		end else if (hit(avs_address, nva_pkg::OFF_INDEX)) begin
			rd_mux = index_reg;
		end else if (hit(avs_address, nva_pkg::OFF_FLAG)) begin
			rd_mux = 8'(done_reg) << nva_pkg::DONE_BIT;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (wait_reg & avs_read) begin
			rdata_reg <= {24'h00_0000, rd_mux};
		end
	end

	// ------------------------------------------------------------
	// Power-up write lockout
	// ------------------------------------------------------------
	// The enable strap is caught on the first edge after release.
	// lockout timer.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			started_reg <= 1'b0;
			powerup_on_reg <= 1'b0;
			powerup_cnt_reg <= '0;
		end else if (!started_reg) begin
			started_reg <= 1'b1;
			powerup_on_reg <= powerup_timer_en;
		end else if (powerup_block) begin
			powerup_cnt_reg <= powerup_cnt_reg + PW'(1);
		end
	end

	assign powerup_block = ~started_reg | (powerup_on_reg &
		(powerup_cnt_reg != PW'(POWERUP_DELAY_CYCLES - 1)));

	// ------------------------------------------------------------
	// Unlock sequence
	// ------------------------------------------------------------
	// exact spacing between steps.
	assign gap_ok = gap_reg == 4'(nva_pkg::KEY_GAP_CYCLES - 1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg <= 4'h0;
		end else if (acc_rd | acc_wr) begin
			gap_reg <= 4'h0;
		end else if (gap_reg != 4'hf) begin
			gap_reg <= gap_reg + 4'h1;
		end
	end

	// any other access breaks the sequence.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			key_reg <= nva_pkg::KEY_IDLE;
		end else if (sys_abort) begin
			key_reg <= nva_pkg::KEY_IDLE;
		end else if (acc_rd | acc_wr) begin
			if (key_wr && wbyte == nva_pkg::KEY_FIRST) begin
				key_reg <= nva_pkg::KEY_HALF;
			end else if (key_wr && wbyte == nva_pkg::KEY_SECOND &&
				key_reg == nva_pkg::KEY_HALF && gap_ok) begin
				key_reg <= nva_pkg::KEY_FULL;
			end else begin
				key_reg <= nva_pkg::KEY_IDLE;
			end
		end
	end

	// ------------------------------------------------------------
	// Store engine
	// ------------------------------------------------------------
	assign busy = st_reg == nva_pkg::ST_BUSY;
	assign st_last = st_cnt_reg == CW'(STORE_CYCLES - 1);
	// permit, lockout and key gate the start.
	assign store_start = ctl_wr & wbyte[nva_pkg::STORE_BIT] &
		(key_reg == nva_pkg::KEY_FULL) & gap_ok & ctrl_reg.permit &
		~powerup_block & ~busy & ~sys_abort;
	assign store_done = busy & st_last & ~sys_abort;
	assign store_kill = busy & sys_abort;

	// permit is not looked at once busy.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= nva_pkg::ST_IDLE;
			st_cnt_reg <= '0;
		end else begin
			unique case (st_reg)
				nva_pkg::ST_IDLE: begin
					st_cnt_reg <= '0;
					if (store_start) begin
						st_reg <= nva_pkg::ST_BUSY;
					end
				end
				nva_pkg::ST_BUSY: begin
					st_cnt_reg <= st_cnt_reg + CW'(1);
					if (sys_abort | st_last) begin
						st_reg <= nva_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// The target is latched so later register writes cannot redirect it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_addr_reg <= '0;
			st_data_reg <= 8'h00;
		end else if (store_start) begin
			st_addr_reg <= index_reg[ADDR_W-1:0];
			st_data_reg <= byte_reg;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= nva_pkg::CONTROL_RST;
		end else begin
			if (ctl_wr) begin
				ctrl_reg.permit <= wbyte[nva_pkg::PERMIT_BIT];
			end
			if (store_kill) begin
				ctrl_reg.abort <= 1'b1;
			end else if (store_done) begin
				ctrl_reg.abort <= 1'b0;
			end else if (ctl_wr) begin
				ctrl_reg.abort <= wbyte[nva_pkg::ABORT_BIT];
			end
			if (store_start) begin
				ctrl_reg.store <= 1'b1;
			end else if (store_done | store_kill) begin
				ctrl_reg.store <= 1'b0;
			end
			// fetch clears itself one cycle later.
			if (sys_abort | ctrl_reg.fetch) begin
				ctrl_reg.fetch <= 1'b0;
			end else if (ctl_wr & wbyte[nva_pkg::FETCH_BIT]) begin
				ctrl_reg.fetch <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Byte, index and flag registers
	// ------------------------------------------------------------
	// no reset request touches these.
	// byte only changes on fetch or write.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_reg <= nva_pkg::BYTE_RST;
		end else if (ctrl_reg.fetch) begin
			byte_reg <= mem_rdata;
		end else if (acc_wr & lane0 & hit(avs_address, nva_pkg::OFF_BYTE))
			begin
			byte_reg <= wbyte;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			index_reg <= nva_pkg::INDEX_RST;
		end else if (acc_wr & lane0 & hit(avs_address, nva_pkg::OFF_INDEX))
			begin
			index_reg <= wbyte;
		end
	end

	// done flag, set wins over clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
		end else if (store_done) begin
			done_reg <= 1'b1;
		end else if (acc_wr & lane0 & hit(avs_address, nva_pkg::OFF_FLAG) &
			~wbyte[nva_pkg::DONE_BIT]) begin
			done_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Byte array
	// ------------------------------------------------------------
	// cell replaced at end of timed store.
	nva_mem #(
		.DATA_W(8),
		.ADDR_W(ADDR_W)
	) u_mem (
		.clk(clk),
		.rst_n(rst_n),
		.we(store_done),
		.waddr(st_addr_reg),
		.wdata(st_data_reg),
		.raddr(index_reg[ADDR_W-1:0]),
		.rdata(mem_rdata)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [CW:0] busy_len_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_len_reg <= '0;
		end else if (busy) begin
			busy_len_reg <= busy_len_reg + (CW+1)'(1);
		end else begin
			busy_len_reg <= '0;
		end
	end

	ctrl_upper_zero_a: assert property (
		(wait_reg && avs_read && hit(avs_address, nva_pkg::OFF_CONTROL))
		|=> !avs_waitrequest && avs_readdata[31:4] == 28'h0)
		else $error("control upper bits not zero");
	store_trig_hold_a: assert property (
		(ctrl_reg.store && !store_done && !sys_abort) |=> ctrl_reg.store)
		else $error("store trigger dropped early");
	permit_gate_a: assert property (
		(!ctrl_reg.permit && !ctrl_reg.store) |=> !ctrl_reg.store)
		else $error("store set without permit");
	abort_flag_a: assert property (
		store_kill |=> ctrl_reg.abort && !busy && !ctrl_reg.store)
		else $error("aborted store not flagged");
	regs_retained_a: assert property (
		(sys_abort && !acc_wr && !ctrl_reg.fetch)
		|=> $stable(index_reg) && $stable(byte_reg))
		else $error("registers changed by reset request");
	done_flag_a: assert property (
		store_done |=> done_reg && !ctrl_reg.store && !ctrl_reg.abort)
		else $error("completion not flagged");
	key_reads_zero_a: assert property (
		(wait_reg && avs_read && hit(avs_address, nva_pkg::OFF_KEY))
		|=> avs_readdata == 32'h0000_0000)
		else $error("key port read not zero");
	fetch_load_a: assert property (
		ctrl_reg.fetch |=> !ctrl_reg.fetch && byte_reg == $past(mem_rdata))
		else $error("fetch did not load byte");
	byte_hold_a: assert property (
		(!ctrl_reg.fetch && !acc_wr) |=> $stable(byte_reg))
		else $error("byte register changed");
	unlock_order_a: assert property (
		$rose(ctrl_reg.store) |-> $past(key_reg) == nva_pkg::KEY_FULL
		&& $past(gap_reg) == 4'(nva_pkg::KEY_GAP_CYCLES - 1))
		else $error("store started without unlock");
	busy_holds_a: assert property (
		(busy && !st_last && !sys_abort) |=> busy)
		else $error("store ended early");
	permit_sw_only_a: assert property (
		!ctl_wr |=> $stable(ctrl_reg.permit))
		else $error("permit changed by hardware");
	lockout_a: assert property (
		powerup_block |=> !$rose(ctrl_reg.store))
		else $error("store during power-up lockout");
	store_len_a: assert property (
		$fell(busy) && !$past(sys_abort)
		|-> $past(busy_len_reg) == (CW+1)'(STORE_CYCLES - 1))
		else $error("store length wrong");

	fetch_c: cover property (ctrl_reg.fetch);
	store_done_c: cover property (store_done);
	store_kill_c: cover property (store_kill);
	unlock_refused_c: cover property (
		ctl_wr && wbyte[nva_pkg::STORE_BIT] && !store_start && !busy);

endmodule : nva_ctrl

/* tb/nva_fw_master.sv */
/*
 * Firmware-side model: an Avalon-MM master standing in for the CPU core,
 * with single register accesses and the unlock-and-store sequence.
 * Assumes a slave with waitrequest that idles high and answers each access.
 */
module nva_fw_master (
	input wire logic clk,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	output logic hung
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h1;
		hung = 1'b0;
	end

	// ------------------------------------------------------------
	// Single access
	// ------------------------------------------------------------
	// With hold set the request stays up so the next call follows at once,
	// which is the only way to meet the two-edge spacing of the key sequence.
	task automatic acc(input logic wr, input logic [7:0] adr,
		input logic [7:0] dat, input logic hold, output logic [7:0] rd);
		int n;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_address <= adr;
		avs_writedata <= {24'h000000, dat};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			hung <= 1'b1;
		end
		rd = avs_readdata[7:0];
		if (!hold) begin
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			avs_address <= ~adr;
			avs_writedata <= ~{24'h000000, dat};
			@(posedge clk);
		end
	endtask : acc

	// ------------------------------------------------------------
	// Store start sequence
	// ------------------------------------------------------------
	// Mode 1 swaps the keys and mode 2 leaves an idle cycle after the
	// first key; any other mode is the correct sequence.
	// keys, no interruption
	task automatic store_seq(input logic [1:0] mode, input logic [7:0] ctl);
		logic [7:0] d;
		acc(1'b1, nva_pkg::OFF_KEY, (mode == 2'd1) ? nva_pkg::KEY_SECOND :
			nva_pkg::KEY_FIRST, mode != 2'd2, d);
		acc(1'b1, nva_pkg::OFF_KEY, (mode == 2'd1) ? nva_pkg::KEY_FIRST :
			nva_pkg::KEY_SECOND, 1'b1, d);
		acc(1'b1, nva_pkg::OFF_CONTROL, ctl, 1'b0, d);
	endtask : store_seq
endmodule : nva_fw_master

/* tb/testbench.sv */
/*
 * Self-checking testbench of the data EEPROM access controller.
 * Assumes the firmware master model and shortened timer parameters.
 */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int LOCKOUT = 80;
	localparam int ST = 20;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] rq = 3'b000;
	logic pud_en = 1'b1;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic hung;
	logic [7:0] lf;
	logic [7:0] mem [128];
	logic [7:0] a;
	logic [7:0] b;
	int fails = 0;
	int n_tests = 0;

	always #12.5 clk = ~clk;

	nva_ctrl #(.ADDR_W(7), .POWERUP_DELAY_CYCLES(LOCKOUT),
		.STORE_CYCLES(ST)) uut (
		.clk(clk), .rst_n(rst_n), .external_reset_pin(rq[0]),
		.watchdog_timeout(rq[1]), .brownout_reset(rq[2]),
		.powerup_timer_en(pud_en), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	nva_fw_master fw (
		.clk(clk), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.hung(hung));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	function automatic logic [7:0] ctl(input logic ab, input logic pm,
		input logic st, input logic fe);
		logic [7:0] r;
		r = 8'h00;
		r[nva_pkg::ABORT_BIT] = ab;
		r[nva_pkg::PERMIT_BIT] = pm;
		r[nva_pkg::STORE_BIT] = st;
		r[nva_pkg::FETCH_BIT] = fe;
		return r;
	endfunction : ctl

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
		logic [7:0] d;
		fw.acc(1'b1, adr, dat, 1'b0, d);
	endtask : wr

	task automatic rchk(input string name, input logic [7:0] adr,
		input logic [7:0] exp);
		logic [7:0] d;
		logic [7:0] hi;
		fw.acc(1'b0, adr, 8'h00, 1'b0, d);
		check(name, d, exp);
		hi = avs_readdata[31:24] | avs_readdata[23:16] | avs_readdata[15:8];
		check("upper lanes", hi, 8'h00);
	endtask : rchk

	// Fetch clears the permit bit too, which is what firmware should do.
	task automatic fetch_chk(input logic [7:0] adr, input logic [7:0] exp);
		wr(nva_pkg::OFF_INDEX, adr);
		wr(nva_pkg::OFF_CONTROL, ctl(0, 0, 0, 1));
		rchk("fetched byte", nva_pkg::OFF_BYTE, exp);
		rchk("fetch cleared", nva_pkg::OFF_CONTROL, 8'h00);
		rchk("byte retained", nva_pkg::OFF_BYTE, exp);
	endtask : fetch_chk

	task automatic do_store(input logic [7:0] adr, input logic [7:0] dat,
		input logic [1:0] mode, input logic pm);
		wr(nva_pkg::OFF_INDEX, adr);
		wr(nva_pkg::OFF_BYTE, dat);
		wr(nva_pkg::OFF_CONTROL, ctl(0, pm, 0, 0));
		fw.store_seq(mode, ctl(0, pm, 1, 0));
	endtask : do_store

	task automatic full_store(input logic [7:0] adr, input logic [7:0] dat);
		logic [7:0] d;
		int n;
		do_store(adr, dat, 2'd0, 1'b1);
		rchk("store busy", nva_pkg::OFF_CONTROL, ctl(0, 1, 1, 0));
		wr(nva_pkg::OFF_CONTROL, 8'h00);
		rchk("store held", nva_pkg::OFF_CONTROL, ctl(0, 0, 1, 0));
		rchk("flag busy", nva_pkg::OFF_FLAG, 8'h00);
		n = 0;
		do begin
			fw.acc(1'b0, nva_pkg::OFF_CONTROL, 8'h00, 1'b0, d);
			n++;
		end while (d[nva_pkg::STORE_BIT] !== 1'b0 && n < 20);
		check("store ends", d, 8'h00);
		rchk("done flag", nva_pkg::OFF_FLAG, 8'h80);
		wr(nva_pkg::OFF_FLAG, 8'h00);
		rchk("flag cleared", nva_pkg::OFF_FLAG, 8'h00);
		mem[adr[6:0]] = dat;
		fetch_chk(adr, dat);
	endtask : full_store

	always @(posedge hung) begin
		fails++;
		finish_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		lf = 8'h55;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk("control reset", nva_pkg::OFF_CONTROL, 8'h00);
		rchk("key port", nva_pkg::OFF_KEY, 8'h00);
		rchk("flag reset", nva_pkg::OFF_FLAG, 8'h00);
		rchk("unmapped", 8'hb0, 8'h00);
		wr(nva_pkg::OFF_CONTROL, 8'hf4);
		rchk("upper bits", nva_pkg::OFF_CONTROL, ctl(0, 1, 0, 0));
		// The power-up lockout is still running here.
		do_store(8'h11, 8'h3c, 2'd0, 1'b1);
		rchk("lockout", nva_pkg::OFF_CONTROL, ctl(0, 1, 0, 0));
		repeat (LOCKOUT) @(posedge clk);
		rchk("no done", nva_pkg::OFF_FLAG, 8'h00);
		for (int i = 0; i < 6; i++) begin
			lf = lfsr(lf);
			a = (i == 0) ? 8'h7f : {1'b0, lf[6:0]};
			lf = lfsr(lf);
			b = lf;
			full_store(a, b);
		end
		// Broken sequences: swapped keys, a gap, permit clear.
		for (int m = 1; m < 4; m++) begin
			do_store(a, ~b, m[1:0], m != 3);
			rchk("refused", nva_pkg::OFF_CONTROL, ctl(0, m != 3, 0, 0));
			rchk("refused flag", nva_pkg::OFF_FLAG, 8'h00);
			fetch_chk(a, mem[a[6:0]]);
		end
		for (int k = 0; k < 3; k++) begin
			do_store(a, ~b, 2'd0, 1'b1);
			repeat (3) @(posedge clk);
			rq <= 3'b001 << k;
			@(posedge clk);
			rq <= 3'b000;
			rchk("aborted", nva_pkg::OFF_CONTROL, ctl(1, 1, 0, 0));
			rchk("index kept", nva_pkg::OFF_INDEX, a);
			rchk("byte kept", nva_pkg::OFF_BYTE, ~b);
			rchk("abort flag", nva_pkg::OFF_FLAG, 8'h00);
			fetch_chk(a, mem[a[6:0]]);
		end
		// A second power-up with the delay timer strapped off: permit must
		// clear, the array keeps its bytes and a store needs no waiting.
		wr(nva_pkg::OFF_CONTROL, ctl(0, 1, 0, 0));
		pud_en <= 1'b0;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk("permit at power-up", nva_pkg::OFF_CONTROL, 8'h00);
		fetch_chk(8'h7f, mem[7'h7f]);
		full_store(a, ~b);
		rchk("key port", nva_pkg::OFF_KEY, 8'h00);
		finish_test();
	end
endmodule : testbench
